// ===== logic/rid_pkg.sv
// Constants shared by the instruction decoder and its stack
package rid_pkg;
   localparam int INSTR_W = 13;
   localparam int DATA_W = 8;
   localparam int PC_W = 14;
   localparam int PAGE_W = 4;
   localparam int REG_W = 6;
   localparam int BANK_W = 2;
   localparam int LIT_LONG_W = 10;
   localparam int STACK_DEPTH = 8;
   localparam int FLAG_W = 5;
   // Bank select field in the register select pointer
   localparam int BANK_HI = 7;
   localparam int BANK_LO = 6;
   // Shadowed operational register addresses
   localparam logic [5:0] RSP_ADDR = 6'h04;
   localparam logic [5:0] PAGE_ADDR = 6'h05;
   // Flag positions in the flag output
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_P = 3;
   localparam int FLAG_T = 4;
   // Reset values and the software interrupt vector
   localparam logic [13:0] PC_RESET = 14'h0000;
   localparam logic [13:0] SW_VECTOR = 14'h0001;
   localparam logic [7:0] RSP_RESET = 8'h00;
   localparam logic [3:0] PAGE_RESET = 4'h0;
   localparam logic [4:0] FLAG_RESET = 5'h18;
   // Control codes, low six bits with the upper opcode bits all zero
   localparam logic [5:0] OP_NOP = 6'h00;
   localparam logic [5:0] OP_SLEEP = 6'h03;
   localparam logic [5:0] OP_WDTC = 6'h04;
   localparam logic [5:0] OP_ENI = 6'h10;
   localparam logic [5:0] OP_DISI = 6'h11;
   localparam logic [5:0] OP_RET = 6'h12;
   localparam logic [5:0] OP_RETI = 6'h13;
   localparam logic [5:0] OP_TBL = 6'h20;
   // Register operation groups, opcode bits 10 to 7
   localparam logic [3:0] GRP_CTRL = 4'h0;
   localparam logic [3:0] GRP_CLR = 4'h1;
   localparam logic [3:0] GRP_SUB = 4'h2;
   localparam logic [3:0] GRP_DEC = 4'h3;
   localparam logic [3:0] GRP_OR = 4'h4;
   localparam logic [3:0] GRP_AND = 4'h5;
   localparam logic [3:0] GRP_XOR = 4'h6;
   localparam logic [3:0] GRP_ADD = 4'h7;
   localparam logic [3:0] GRP_MOV = 4'h8;
   localparam logic [3:0] GRP_COM = 4'h9;
   localparam logic [3:0] GRP_INC = 4'ha;
   localparam logic [3:0] GRP_DJZ = 4'hb;
   localparam logic [3:0] GRP_RRC = 4'hc;
   localparam logic [3:0] GRP_RLC = 4'hd;
   localparam logic [3:0] GRP_SWAP = 4'he;
   localparam logic [3:0] GRP_IJZ = 4'hf;
   // Single-bit operations, opcode bits 10 to 9
   localparam logic [1:0] BIT_CLR = 2'h0;
   localparam logic [1:0] BIT_SET = 2'h1;
   localparam logic [1:0] BIT_SKIP_CLR = 2'h2;
   localparam logic [1:0] BIT_SKIP_SET = 2'h3;
   // Literal operations, opcode bits 11 to 8
   localparam logic [3:0] LIT_MOV = 4'h8;
   localparam logic [3:0] LIT_OR = 4'h9;
   localparam logic [3:0] LIT_AND = 4'ha;
   localparam logic [3:0] LIT_XOR = 4'hb;
   localparam logic [3:0] LIT_RETURN_WITH_LITERAL = 4'hc;
   localparam logic [3:0] LIT_SUB = 4'hd;
   localparam logic [3:0] LIT_MISC = 4'he;
   localparam logic [3:0] LIT_ADD = 4'hf;
   localparam logic [7:0] LIT_SWINT = 8'h01;
   localparam logic [3:0] LIT_PAGE_HI = 4'h8;
   typedef enum logic [1:0] {
      RID_FETCH = 2'b00,
      RID_EXEC = 2'b01,
      RID_SLEEP = 2'b10
   } rid_phase_e;
endpackage : rid_pkg

// ===== logic/rid_stack.sv
// Return address stack held in flip-flops, wrapping pointer
`timescale 1ns/1ns
module rid_stack #(
   parameter int DEPTH = rid_pkg::STACK_DEPTH,
   parameter int WIDTH = rid_pkg::PC_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] top
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] ptr_q;
   logic [PTR_W-1:0] top_idx;

   assign top_idx = ptr_q - PTR_W'(1);
   assign top = mem_q[top_idx];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= '0;
      end else if (push) begin
         ptr_q <= ptr_q + PTR_W'(1);
      end else if (pop) begin
         ptr_q <= top_idx;
      end
   end

   genvar g;
   for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            mem_q[g] <= '0;
         end else if (push && ptr_q == PTR_W'(g)) begin
            mem_q[g] <= din;
         end
      end
   end
endmodule : rid_stack

// ===== logic/rid_decoder.sv
// Instruction decode and execute unit of the 8-bit core
//
// Behaviour
// - Register field addresses one of 64 registers in the selected bank.
// - Bank comes from bits 6 and 7 of the register select pointer.
// - I/O registers use the same register-operand instructions as others.
// - Bit ops: 100b clear, 101b set, 110b skip if zero, 111b skip if one.
// - Bit selector picks the bit position within the addressed register.
// - Literals are 8 bits for accumulator ops, 10 bits for call and jump.
// - Sleep clears watchdog, stops oscillator, updates timeout and power-down.
// - Table lookup adds accumulator to counter low part; sets Z, C, DC.
// - Decrement-and-skip writes R-1 and skips on zero, flags unchanged.
// - Increment-and-skip writes R+1 and skips on zero, flags unchanged.
// - Rotate right through carry: bit 0 to carry, carry to bit 7.
// - Rotate left through carry: bit 7 to carry, carry to bit 0.
// - Call and jump load page plus literal; call also pushes return.
// - Return with literal loads accumulator and pops counter, flags kept.
// - Software interrupt pushes return address and vectors to 001H.
`timescale 1ns/1ns
module rid_decoder #(
   parameter int STACK_DEPTH = rid_pkg::STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [rid_pkg::INSTR_W-1:0] instr,
   input wire logic [rid_pkg::DATA_W-1:0] reg_rdata,
   input wire logic wake,
   output logic [rid_pkg::PC_W-1:0] pc_q,
   output logic [rid_pkg::BANK_W+rid_pkg::REG_W-1:0] reg_addr_q,
   output logic [rid_pkg::DATA_W-1:0] reg_wdata_q,
   output logic reg_we_q,
   output logic [rid_pkg::DATA_W-1:0] acc_q,
   output logic [rid_pkg::FLAG_W-1:0] flags_q,
   output logic int_enable_q,
   output logic wdt_clear_q,
   output logic osc_stop_q
);
   localparam int PC_W = rid_pkg::PC_W;

   rid_pkg::rid_phase_e phase_q;
   logic [rid_pkg::INSTR_W-1:0] ir_q;
   logic [rid_pkg::DATA_W-1:0] rsp_q;
   logic [rid_pkg::PAGE_W-1:0] page_q;
   logic skip_q;
   logic wake_s1_q;
   logic wake_s2_q;
   logic [PC_W-1:0] stack_top;
   logic exec;

   // Combinational execute results
   logic [7:0] res;
   logic wr_reg;
   logic wr_acc;
   logic upd_z;
   logic upd_c;
   logic upd_dc;
   logic c_n;
   logic dc_n;
   logic skip_n;
   logic [PC_W-1:0] pc_n;
   logic push;
   logic pop;
   logic do_sleep;
   logic do_wdtc;
   logic ie_set;
   logic ie_clr;
   logic page_wr;
   logic [9:0] sum;
   logic [7:0] mask;
   logic [PC_W-1:0] pc_inc;
   logic [7:0] k8;
   logic [PC_W-1:0] long_target;

   // Returns {digit carry, carry, result} of x + y + cin
   function automatic logic [9:0] add8(input logic [7:0] x, input logic [7:0] y,
                                       input logic cin);
      logic [4:0] lo;
      logic [8:0] full;
      lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
      return {lo[4], full};
   endfunction : add8

   assign exec = (phase_q == rid_pkg::RID_EXEC);
   assign pc_inc = pc_q + PC_W'(1);
   assign k8 = ir_q[7:0];
   assign long_target = {page_q, ir_q[rid_pkg::LIT_LONG_W-1:0]};

   rid_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PC_W)
   ) u_stack (
      .clk(clk),
      .rst_n(rst_n),
      .push(push),
      .pop(pop),
      .din(pc_inc),
      .top(stack_top)
   );

   always_comb begin
      res = acc_q;
      wr_reg = 1'b0;
      wr_acc = 1'b0;
      upd_z = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      c_n = flags_q[rid_pkg::FLAG_C];
      dc_n = flags_q[rid_pkg::FLAG_DC];
      skip_n = 1'b0;
      pc_n = pc_inc;
      push = 1'b0;
      pop = 1'b0;
      do_sleep = 1'b0;
      do_wdtc = 1'b0;
      ie_set = 1'b0;
      ie_clr = 1'b0;
      page_wr = 1'b0;
      sum = 10'h000;
      mask = 8'h01 << ir_q[8:6];
      if (!exec || skip_q) begin
         // Skipped word executes as a no-operation
      end else if (!ir_q[12]) begin
         if (ir_q[11]) begin
            unique case (ir_q[10:9])
               rid_pkg::BIT_CLR: begin
                  res = reg_rdata & ~mask;
                  wr_reg = 1'b1;
               end
               rid_pkg::BIT_SET: begin
                  res = reg_rdata | mask;
                  wr_reg = 1'b1;
               end
               rid_pkg::BIT_SKIP_CLR: skip_n = ((reg_rdata & mask) == 8'h00);
               rid_pkg::BIT_SKIP_SET: skip_n = ((reg_rdata & mask) != 8'h00);
            endcase
         end else begin
            // Bit 6 picks the register as destination, else the accumulator
            wr_reg = ir_q[6];
            wr_acc = !ir_q[6];
            unique case (ir_q[10:7])
               rid_pkg::GRP_CTRL: begin
                  wr_acc = 1'b0;
                  if (ir_q[6]) begin
                     res = acc_q;
                  end else begin
                     wr_reg = 1'b0;
                     unique case (ir_q[5:0])
                        rid_pkg::OP_SLEEP: do_sleep = 1'b1;
                        rid_pkg::OP_WDTC: do_wdtc = 1'b1;
                        rid_pkg::OP_ENI: ie_set = 1'b1;
                        rid_pkg::OP_DISI: ie_clr = 1'b1;
                        rid_pkg::OP_RET: begin
                           pop = 1'b1;
                           pc_n = stack_top;
                        end
                        rid_pkg::OP_RETI: begin
                           pop = 1'b1;
                           pc_n = stack_top;
                           ie_set = 1'b1;
                        end
                        rid_pkg::OP_TBL: begin
                           sum = add8(pc_inc[7:0], acc_q, 1'b0);
                           pc_n = {pc_inc[PC_W-1:8], sum[7:0]};
                           res = sum[7:0];
                           upd_z = 1'b1;
                           upd_c = 1'b1;
                           upd_dc = 1'b1;
                           c_n = sum[8];
                           dc_n = sum[9];
                        end
                        default: begin
                           // Codes outside this unit act as no-operation
                        end
                     endcase
                  end
               end
               rid_pkg::GRP_CLR: begin
                  res = 8'h00;
                  upd_z = 1'b1;
               end
               rid_pkg::GRP_SUB: begin
                  sum = add8(reg_rdata, ~acc_q, 1'b1);
                  res = sum[7:0];
                  upd_z = 1'b1;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                  c_n = sum[8];
                  dc_n = sum[9];
               end
               rid_pkg::GRP_DEC: begin
                  res = reg_rdata - 8'h01;
                  upd_z = 1'b1;
               end
               rid_pkg::GRP_OR: begin
                  res = acc_q | reg_rdata;
                  upd_z = 1'b1;
               end
               rid_pkg::GRP_AND: begin
                  res = acc_q & reg_rdata;
                  upd_z = 1'b1;
               end
               rid_pkg::GRP_XOR: begin
                  res = acc_q ^ reg_rdata;
                  upd_z = 1'b1;
               end
               rid_pkg::GRP_ADD: begin
                  sum = add8(acc_q, reg_rdata, 1'b0);
                  res = sum[7:0];
                  upd_z = 1'b1;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                  c_n = sum[8];
                  dc_n = sum[9];
               end
               rid_pkg::GRP_MOV: begin
                  res = reg_rdata;
                  upd_z = 1'b1;
               end
               rid_pkg::GRP_COM: begin
                  res = ~reg_rdata;
                  upd_z = 1'b1;
               end
               rid_pkg::GRP_INC: begin
                  res = reg_rdata + 8'h01;
                  upd_z = 1'b1;
               end
               rid_pkg::GRP_DJZ: begin
                  res = reg_rdata - 8'h01;
                  skip_n = (res == 8'h00);
               end
               rid_pkg::GRP_RRC: begin
                  res = {flags_q[rid_pkg::FLAG_C], reg_rdata[7:1]};
                  upd_c = 1'b1;
                  c_n = reg_rdata[0];
               end
               rid_pkg::GRP_RLC: begin
                  res = {reg_rdata[6:0], flags_q[rid_pkg::FLAG_C]};
                  upd_c = 1'b1;
                  c_n = reg_rdata[7];
               end
               rid_pkg::GRP_SWAP: res = {reg_rdata[3:0], reg_rdata[7:4]};
               rid_pkg::GRP_IJZ: begin
                  res = reg_rdata + 8'h01;
                  skip_n = (res == 8'h00);
               end
            endcase
         end
      end else begin
         unique case (ir_q[11:10])
            2'b00: begin
               push = 1'b1;
               pc_n = long_target;
            end
            2'b01: pc_n = long_target;
            default: begin
               unique case (ir_q[11:8])
                  rid_pkg::LIT_MOV: begin
                     res = k8;
                     wr_acc = 1'b1;
                  end
                  rid_pkg::LIT_OR: begin
                     res = acc_q | k8;
                     wr_acc = 1'b1;
                     upd_z = 1'b1;
                  end
                  rid_pkg::LIT_AND: begin
                     res = acc_q & k8;
                     wr_acc = 1'b1;
                     upd_z = 1'b1;
                  end
                  rid_pkg::LIT_XOR: begin
                     res = acc_q ^ k8;
                     wr_acc = 1'b1;
                     upd_z = 1'b1;
                  end
                  rid_pkg::LIT_RETURN_WITH_LITERAL: begin
                     res = k8;
                     wr_acc = 1'b1;
                     pop = 1'b1;
                     pc_n = stack_top;
                  end
                  rid_pkg::LIT_SUB, rid_pkg::LIT_ADD: begin
                     if (ir_q[8]) begin
                        sum = add8(k8, acc_q, 1'b0);
                     end else begin
                        sum = add8(k8, ~acc_q, 1'b1);
                     end
                     res = sum[7:0];
                     wr_acc = 1'b1;
                     upd_z = 1'b1;
                     upd_c = 1'b1;
                     upd_dc = 1'b1;
                     c_n = sum[8];
                     dc_n = sum[9];
                  end
                  rid_pkg::LIT_MISC: begin
                     if (k8 == rid_pkg::LIT_SWINT) begin
                        push = 1'b1;
                        pc_n = rid_pkg::SW_VECTOR;
                     end else if (k8[7:4] == rid_pkg::LIT_PAGE_HI) begin
                        page_wr = 1'b1;
                     end
                  end
                  default: begin
                     // Long forms are taken by the outer case
                  end
               endcase
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end else begin
         wake_s1_q <= wake;
         wake_s2_q <= wake_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= rid_pkg::RID_FETCH;
         osc_stop_q <= 1'b0;
      end else begin
         unique case (phase_q)
            rid_pkg::RID_FETCH: phase_q <= rid_pkg::RID_EXEC;
            rid_pkg::RID_EXEC: begin
               if (do_sleep) begin
                  phase_q <= rid_pkg::RID_SLEEP;
                  osc_stop_q <= 1'b1;
               end else begin
                  phase_q <= rid_pkg::RID_FETCH;
               end
            end
            rid_pkg::RID_SLEEP: begin
               if (wake_s2_q) begin
                  phase_q <= rid_pkg::RID_FETCH;
                  osc_stop_q <= 1'b0;
               end
            end
            default: phase_q <= rid_pkg::RID_FETCH;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_q <= '0;
         reg_addr_q <= '0;
      end else if (phase_q == rid_pkg::RID_FETCH) begin
         ir_q <= instr;
         reg_addr_q <= {rsp_q[rid_pkg::BANK_HI:rid_pkg::BANK_LO], instr[5:0]};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= rid_pkg::PC_RESET;
         skip_q <= 1'b0;
      end else if (exec) begin
         pc_q <= pc_n;
         skip_q <= skip_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Architectural state

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_we_q <= 1'b0;
         reg_wdata_q <= '0;
      end else begin
         reg_we_q <= wr_reg;
         reg_wdata_q <= wr_reg ? res : reg_wdata_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= '0;
      end else if (wr_acc) begin
         acc_q <= res;
      end
   end

   // Shadows of the bank pointer and page register follow register writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= rid_pkg::RSP_RESET;
         page_q <= rid_pkg::PAGE_RESET;
      end else begin
         if (wr_reg && ir_q[5:0] == rid_pkg::RSP_ADDR) begin
            rsp_q <= res;
         end
         if (page_wr) begin
            page_q <= k8[rid_pkg::PAGE_W-1:0];
         end else if (wr_reg && ir_q[5:0] == rid_pkg::PAGE_ADDR) begin
            page_q <= res[rid_pkg::PAGE_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= rid_pkg::FLAG_RESET;
         wdt_clear_q <= 1'b0;
         int_enable_q <= 1'b0;
      end else begin
         if (upd_z) begin
            flags_q[rid_pkg::FLAG_Z] <= (res == 8'h00);
         end
         if (upd_c) begin
            flags_q[rid_pkg::FLAG_C] <= c_n;
         end
         if (upd_dc) begin
            flags_q[rid_pkg::FLAG_DC] <= dc_n;
         end
         if (do_sleep || do_wdtc) begin
            flags_q[rid_pkg::FLAG_T] <= 1'b1;
            flags_q[rid_pkg::FLAG_P] <= do_wdtc;
         end
         wdt_clear_q <= do_sleep || do_wdtc;
         if (ie_set) begin
            int_enable_q <= 1'b1;
         end else if (ie_clr) begin
            int_enable_q <= 1'b0;
         end
      end
   end
endmodule : rid_decoder

// ===== test/rid_mem_model.sv
// Program memory and register file seen by the decode unit
`timescale 1ns/1ns
module rid_mem_model (
   input wire logic clk,
   input wire logic [13:0] pc,
   input wire logic [7:0] reg_addr,
   input wire logic reg_we,
   input wire logic [7:0] reg_wdata,
   output logic [12:0] instr,
   output logic [7:0] reg_rdata
);
   logic [12:0] rom [0:255];
   // Four banks of 64 registers, I/O ones among them
   logic [7:0] ram [0:255];
   assign instr = rom[pc[7:0]];
   assign reg_rdata = ram[reg_addr];
   always @(posedge clk) begin
      if (reg_we) begin
         ram[reg_addr] <= reg_wdata;
      end
   end
endmodule : rid_mem_model

// ===== test/rid_decoder_checker.sv
// Port-level assertions for the instruction decode unit
`timescale 1ns/1ns
module rid_decoder_checker #(
   parameter int STACK_DEPTH = rid_pkg::STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [12:0] instr,
   input wire logic [7:0] reg_addr_q,
   input wire logic reg_we_q,
   input wire logic [13:0] pc_q,
   input wire logic [7:0] acc_q,
   input wire logic [4:0] flags_q,
   input wire logic wdt_clear_q,
   input wire logic osc_stop_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   chk_reg_field: assert property (
      $changed(reg_addr_q) |-> reg_addr_q[5:0] == $past(instr[5:0])) else $error("reg field");
   chk_we_pulse: assert property (
      reg_we_q |=> !reg_we_q && $stable(pc_q)) else $error("write pulse");
   chk_we_cause: assert property (
      reg_we_q |-> $changed(pc_q)) else $error("write without execute");
   chk_pc_pace: assert property (
      $changed(pc_q) |=> $stable(pc_q)) else $error("counter pace");
   chk_wdt_pulse: assert property (
      wdt_clear_q |=> !wdt_clear_q) else $error("watchdog pulse");
   chk_sleep_entry: assert property (
      $rose(osc_stop_q) |-> wdt_clear_q && flags_q[4] && !flags_q[3]) else $error("sleep entry");
   chk_sleep_hold: assert property (
      osc_stop_q |=> $stable(pc_q) && $stable(acc_q)) else $error("sleep hold");
   chk_skip_flags: assert property (
      $changed(pc_q) && $past(instr[12:7]) inside {6'h0b, 6'h0f} |-> flags_q == $past(flags_q))
      else $error("skip op flags");
   chk_return_with_literal_flags: assert property (
      $changed(pc_q) && $past(instr[12:8]) == 5'h1c |-> $stable(flags_q))
      else $error("return flags");
   chk_jump_target: assert property (
      $changed(pc_q) && $past(instr[12:11]) == 2'h2
      |-> pc_q[9:0] == $past(instr[9:0]) || pc_q == $past(pc_q) + 14'h1) else $error("target");
   chk_tbl_page: assert property (
      $changed(pc_q) && $past(instr) == 13'h0020
      |-> pc_q[13:8] == $past(pc_q[13:8]) || pc_q == $past(pc_q) + 14'h1) else $error("table");
   chk_int_vector: assert property (
      $changed(pc_q) && $past(instr) == 13'h1e01
      |-> pc_q == 14'h1 || pc_q == $past(pc_q) + 14'h1) else $error("soft vector");
endmodule : rid_decoder_checker

bind rid_decoder rid_decoder_checker #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.clk(clk),
   .rst_n(rst_n), .instr(instr), .reg_addr_q(reg_addr_q), .reg_we_q(reg_we_q), .pc_q(pc_q),
   .acc_q(acc_q), .flags_q(flags_q), .wdt_clear_q(wdt_clear_q), .osc_stop_q(osc_stop_q));

// ===== test/testbench.sv
// Self-checking bench for the instruction decode unit
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wake = 1'b0;
   logic [12:0] instr;
   logic [7:0] reg_rdata;
   logic [13:0] pc_q;
   logic [7:0] reg_addr_q;
   logic [7:0] reg_wdata_q;
   logic reg_we_q;
   logic [7:0] acc_q;
   logic [4:0] flags_q;
   logic int_enable_q;
   logic wdt_clear_q;
   logic osc_stop_q;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int i;
   // Rows: address, word, next counter, accumulator, carry
   logic [43:0] rows [0:37] = '{
      44'h00_185a_01_5a_0, 44'h01_0050_02_5a_0, 44'h02_0510_03_5b_0, 44'h03_0610_04_2d_0,
      44'h04_0690_05_b4_0, 44'h05_18ff_06_ff_0, 44'h06_1f01_07_00_1, 44'h07_0610_08_ad_0,
      44'h08_1f80_09_2d_1, 44'h09_0690_0a_b5_0, 44'h0a_0bd0_0b_b5_0, 44'h0b_0e10_0c_b5_0,
      44'h0c_0dd0_0d_b5_0, 44'h0d_0fd0_0e_b5_0, 44'h0e_1811_0f_b5_0, 44'h0f_09d0_10_b5_0,
      44'h10_0c10_11_b5_0, 44'h11_1822_12_b5_0, 44'h12_0410_13_5a_0, 44'h13_1801_14_01_0,
      44'h14_0051_15_01_0, 44'h15_05d1_16_01_0, 44'h16_1833_17_01_0, 44'h17_0411_18_00_0,
      44'h18_18ff_19_ff_0, 44'h19_0051_1a_ff_0, 44'h1a_0791_1b_00_0, 44'h1b_1844_1c_00_0,
      44'h1c_0590_1d_59_0, 44'h1d_1440_40_59_0, 44'h40_1050_50_59_0, 44'h50_1c77_41_77_0,
      44'h41_1802_42_02_0, 44'h42_0020_45_02_0, 44'h45_1840_46_40_0, 44'h46_0044_47_40_0,
      44'h47_0050_48_40_0, 44'h48_1e01_01_40_0};

   rid_decoder u_rid_decoder (.clk(clk), .rst_n(rst_n), .instr(instr), .reg_rdata(reg_rdata),
      .wake(wake), .pc_q(pc_q), .reg_addr_q(reg_addr_q), .reg_wdata_q(reg_wdata_q),
      .reg_we_q(reg_we_q), .acc_q(acc_q), .flags_q(flags_q), .int_enable_q(int_enable_q),
      .wdt_clear_q(wdt_clear_q), .osc_stop_q(osc_stop_q));
   rid_mem_model u_mem (.clk(clk), .pc(pc_q), .reg_addr(reg_addr_q), .reg_we(reg_we_q),
      .reg_wdata(reg_wdata_q), .instr(instr), .reg_rdata(reg_rdata));

   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic check_val(input logic [13:0] got, input logic [13:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_val

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      for (i = 0; i < 256; i++) begin
         u_mem.rom[i] = 13'h0000;
         u_mem.ram[i] = 8'h00;
      end
      for (i = 0; i < 38; i++) begin
         u_mem.rom[rows[i][43:36]] = rows[i][32:20];
      end
      do_reset();
      #1;
      check_val(pc_q, 14'h0000, "reset counter");
      check_val(flags_q, 5'h18, "reset flags");
      check_val({osc_stop_q, reg_we_q, acc_q}, 10'h000, "reset outputs");
      for (i = 0; i < 38; i++) begin
         repeat (2) @(posedge clk);
         #1;
         check_val(pc_q, {6'h00, rows[i][19:12]}, "counter");
         check_val(acc_q, rows[i][11:4], "accumulator");
         check_val(flags_q[rid_pkg::FLAG_C], rows[i][0], "carry");
      end
      check_val(u_mem.ram[8'h10], 8'h5a, "bit ops result");
      check_val(u_mem.ram[8'h11], 8'hff, "register 11");
      check_val(u_mem.ram[8'h50], 8'h40, "bank one write");
      // Sleep, then watchdog clear, then a literal load after waking
      u_mem.rom[0] = 13'h0003;
      u_mem.rom[1] = 13'h0004;
      u_mem.rom[2] = 13'h1899;
      @(posedge clk);
      do_reset();
      repeat (2) @(posedge clk);
      #1;
      check_val(osc_stop_q, 1'b1, "oscillator stop");
      check_val(wdt_clear_q, 1'b1, "watchdog clear");
      check_val(flags_q[4:3], 2'h2, "timeout and power-down");
      repeat (6) @(posedge clk);
      check_val(pc_q, 14'h0001, "asleep counter");
      wake <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         if (!osc_stop_q) break;
      end
      check_val(osc_stop_q, 1'b0, "woken");
      @(posedge clk);
      wake <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         if (wdt_clear_q) break;
      end
      check_val({wdt_clear_q, flags_q[4:3]}, 3'h7, "watchdog clear op");
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         if (acc_q === 8'h99) break;
      end
      check_val(acc_q, 8'h99, "resumed");
      print_verdict();
   end
endmodule : testbench
